// *** core/hsio_pkg.sv ***
// shared constants and types for the host interface select block
package hsio_pkg;

   // core clock rate
   localparam int unsigned CORE_CLK_HZ = 10_000_000;

   // button hold time before the factory restore fires, in seconds
   localparam int unsigned FACTORY_HOLD_S = 10;
   localparam int unsigned FACTORY_HOLD_CYCLES = FACTORY_HOLD_S * CORE_CLK_HZ;

   // core cycles after reset before the buttons are caught
   localparam int unsigned BUTTON_SAMPLE_CYCLES = 8;

   // core cycles spent looking for the reference clock
   localparam int unsigned ETH_WAIT_CYCLES = 64;

   // half period of the data-pending toggle during detection
   localparam int unsigned PENDING_TOGGLE_CYCLES = 32;

   // lamp blank time after data activity
   localparam int unsigned FLASH_CYCLES = 16;

   // half period of the management clock, in core cycles
   localparam int unsigned MGMT_HALF_CYCLES = 4;

   // serial clock pulses that confirm a master
   localparam int unsigned SPI_DETECT_PULSES = 8;

   // serial frame layout
   localparam int unsigned UART_DATA_BITS = 8;
   localparam int unsigned UART_STOP_BITS = 1;

   // reference clock divider bit watched by the core
   localparam int unsigned RMII_DIV_BIT = 3;

   // transaction limits for the master
   localparam int unsigned SPI_MIN_BYTES = 8;
   localparam int unsigned SPI_MAX_BYTES = 4096;
   localparam int unsigned SPI_BYTE_GRAIN = 4;

   // chosen host interface
   typedef enum logic [1:0] {
      IF_NONE,
      IF_UART,
      IF_ETH,
      IF_SPI
   } hsio_if_e;

   // status shown on the lamps
   typedef enum logic [1:0] {
      ST_DATA_IDLE,
      ST_CMD_IDLE,
      ST_CONNECTING,
      ST_CONNECTED
   } hsio_status_e;

endpackage

// *** core/hsio_link_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// pins between the module and its host
interface hsio_link_if;
   logic spiClk;
   logic spiCsN;
   logic spiMosi;
   logic spiMiso;
   logic dataPending;
   logic rxFull;
   logic uartToDev;
   logic uartFromDev;
   logic ctsN;
   logic rtsN;
   logic hostStateN;

   modport device (
      input spiClk, spiCsN, spiMosi, uartToDev, ctsN, hostStateN,
      output spiMiso, dataPending, rxFull, uartFromDev, rtsN
   );

   modport host (
      output spiClk, spiCsN, spiMosi, uartToDev, ctsN, hostStateN,
      input spiMiso, dataPending, rxFull, uartFromDev, rtsN
   );
endinterface
`default_nettype wire

// *** core/hsio_sync3.sv ***
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser, output moves once stages two and three agree
module hsio_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1Reg;
   logic [W-1:0] s2Reg;
   logic [W-1:0] s3Reg;

   // stage chain and agreement filter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1Reg <= INIT;
         s2Reg <= INIT;
         s3Reg <= INIT;
         dout <= INIT;
      end else begin
         s1Reg <= din;
         s2Reg <= s1Reg;
         s3Reg <= s2Reg;
         for (int i = 0; i < W; i++) begin
            if (s2Reg[i] == s3Reg[i]) begin
               dout[i] <= s3Reg[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** core/hsio_device.sv ***
`timescale 1ns/1ns
`default_nettype none
// Function
// - lamps active low, colours per status
// - flash active lamps on data activity while connecting or connected
// - lamps off while ethernet selected
// - restore button low at start: serial defaults
// - connect button requests a connection
// - both buttons low at start: bootloader
// - held ten seconds: leave bootloader, factory reset
// - host state pin: command mode or disconnect
// - no flow control: handshake pins are GPIO, except rts held high while ethernet selected
// - exactly one interface chosen before parser
// - detection runs until something is found
// - reference clock means ethernet, serial data only
// - toggle data pending during serial-clock detection
// - eight serial clocks select the slave port
// - serial command stops toggle, drops slave port
// - 8 data, 1 stop, even or no parity
// - programmable baud divider
// - clear-to-send in, request-to-send out
// - reference clock from outside, mgmt clock out
// - slave-only serial peripheral port
// - data pending on by default, rx full optional
// - master clocks at most 10 MHz, mode 3
// - transactions 8 to 4096 bytes, multiple of 4
module hsio_device #(
   parameter int unsigned FACTORY_HOLD_CYCLES = hsio_pkg::FACTORY_HOLD_CYCLES,
   parameter int BAUD_W = 16
) (
   // clocks and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic rmiiRefClk,
   // link to the host
   hsio_link_if.device link,
   // buttons and status
   input wire logic restoreBtnN,
   input wire logic connectBtnN,
   input wire hsio_pkg::hsio_status_e statusMode,
   input wire logic dataActivity,
   input wire logic hostPinIsCmd,
   // configuration
   input wire logic [BAUD_W-1:0] baudDiv,
   input wire logic parityEven,
   input wire logic flowCtrlEn,
   input wire logic pendingEn,
   input wire logic rxFullEn,
   input wire logic rxBusy,
   input wire logic spiTxPending,
   input wire logic gpioRtsOut,
   // serial transmit
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   // received serial peripheral bytes
   output logic rxByteValid,
   output logic [7:0] rxByte,
   // lamps and events
   output logic lampGreenN,
   output logic lampBlueN,
   output logic lampRedN,
   output logic restoreSerialPulse,
   output logic bootloaderMode,
   output logic factoryRestorePulse,
   output logic connectReq,
   output logic cmdModeReq,
   output logic disconnectReq,
   output logic gpioCtsIn,
   output hsio_pkg::hsio_if_e hostIf,
   output logic phyMgmtClockOut
);
   ////////////////////////////////////////////////////////////////////////
   // serial clock domain
   logic [2:0] bitCntReg;
   logic [3:0] pulseCntReg;
   logic [7:0] shiftInReg;
   logic [7:0] rxHoldReg;
   logic byteTglReg;
   logic spiSeenReg;
   logic [7:0] misoReg;

   // slave shifter, mode 3: sample on rising edge
   always_ff @(posedge link.spiClk or negedge rst_n) begin
      if (!rst_n) begin
         bitCntReg <= 3'h0;
         shiftInReg <= 8'h00;
         rxHoldReg <= 8'h00;
         byteTglReg <= 1'b0;
      end else if (!link.spiCsN) begin
         bitCntReg <= bitCntReg + 3'h1;
         shiftInReg <= {shiftInReg[6:0], link.spiMosi};
         if (bitCntReg == 3'h7) begin
            rxHoldReg <= {shiftInReg[6:0], link.spiMosi};
            byteTglReg <= ~byteTglReg;
         end
      end
   end

   // count the detection pulses
   always_ff @(posedge link.spiClk or negedge rst_n) begin
      if (!rst_n) begin
         pulseCntReg <= 4'h0;
         spiSeenReg <= 1'b0;
      end else if (!spiSeenReg) begin
         pulseCntReg <= pulseCntReg + 4'h1;
         if (pulseCntReg == 4'(hsio_pkg::SPI_DETECT_PULSES - 1)) begin
            spiSeenReg <= 1'b1;
         end
      end
   end

   // echo the last byte, shifted on the falling edge
   always_ff @(negedge link.spiClk or negedge rst_n) begin
      if (!rst_n) begin
         misoReg <= 8'h00;
      end else if (bitCntReg == 3'h0) begin
         misoReg <= rxHoldReg;
      end else begin
         misoReg <= {misoReg[6:0], 1'b0};
      end
   end
   assign link.spiMiso = misoReg[7];

   ////////////////////////////////////////////////////////////////////////
   // reference clock domain: divided presence marker
   logic [3:0] rmiiDivReg;
   always_ff @(posedge rmiiRefClk or negedge rst_n) begin
      if (!rst_n) begin
         rmiiDivReg <= 4'h0;
      end else begin
         rmiiDivReg <= rmiiDivReg + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // core domain crossings
   logic [7:0] syncIn;
   logic [7:0] syncOut;
   assign syncIn = {rmiiDivReg[hsio_pkg::RMII_DIV_BIT], spiSeenReg, byteTglReg,
                    link.uartToDev, link.ctsN, link.hostStateN, restoreBtnN,
                    connectBtnN};
   hsio_sync3 #(.W(8), .INIT(8'h1f)) uSync (
      .clk(core_clk),
      .rst_n(rst_n),
      .din(syncIn),
      .dout(syncOut)
   );
   logic rmiiS, spiSeenS, byteTglS, uartRxS, ctsS, hostStateS, restoreS, connectS;
   assign {rmiiS, spiSeenS, byteTglS, uartRxS, ctsS, hostStateS, restoreS,
           connectS} = syncOut;

   logic rmiiPrev, byteTglPrev, uartRxPrev, hostStatePrev, connectPrev;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rmiiPrev <= 1'b0;
         byteTglPrev <= 1'b0;
         uartRxPrev <= 1'b1;
         hostStatePrev <= 1'b1;
         connectPrev <= 1'b1;
      end else begin
         rmiiPrev <= rmiiS;
         byteTglPrev <= byteTglS;
         uartRxPrev <= uartRxS;
         hostStatePrev <= hostStateS;
         connectPrev <= connectS;
      end
   end

   // received byte handed over once per toggle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxByteValid <= 1'b0;
         rxByte <= 8'h00;
      end else begin
         rxByteValid <= (byteTglS != byteTglPrev) && (hostIf == hsio_pkg::IF_SPI);
         if (byteTglS != byteTglPrev) begin
            rxByte <= rxHoldReg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interface detection
   typedef enum logic [2:0] {
      DET_ETH,
      DET_RACE,
      SEL_UART,
      SEL_ETH,
      SEL_SPI
   } hsio_det_e;
   hsio_det_e detReg;
   logic [15:0] detCntReg;
   logic pendTglReg;

   // ethernet first, then the serial race
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         detReg <= DET_ETH;
         detCntReg <= 16'h0000;
         pendTglReg <= 1'b0;
         hostIf <= hsio_pkg::IF_NONE;
      end else begin
         unique case (detReg)
            DET_ETH: begin
               detCntReg <= detCntReg + 16'h0001;
               if (rmiiS != rmiiPrev) begin
                  detReg <= SEL_ETH;
                  hostIf <= hsio_pkg::IF_ETH;
               end else if (detCntReg == 16'(hsio_pkg::ETH_WAIT_CYCLES - 1)) begin
                  detReg <= DET_RACE;
                  detCntReg <= 16'h0000;
               end
            end
            DET_RACE: begin
               if (detCntReg == 16'(hsio_pkg::PENDING_TOGGLE_CYCLES - 1)) begin
                  detCntReg <= 16'h0000;
                  pendTglReg <= ~pendTglReg;
               end else begin
                  detCntReg <= detCntReg + 16'h0001;
               end
               if (uartRxPrev && !uartRxS) begin
                  detReg <= SEL_UART;
                  hostIf <= hsio_pkg::IF_UART;
                  pendTglReg <= 1'b0;
               end else if (spiSeenS) begin
                  detReg <= SEL_SPI;
                  hostIf <= hsio_pkg::IF_SPI;
                  pendTglReg <= 1'b0;
               end
            end
            SEL_UART, SEL_ETH, SEL_SPI: begin
               detCntReg <= 16'h0000;
            end
            default: begin
               detReg <= DET_ETH;
            end
         endcase
      end
   end

   // pending and rx-full pins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link.dataPending <= 1'b0;
         link.rxFull <= 1'b0;
      end else begin
         link.dataPending <= (detReg == DET_RACE) ? pendTglReg :
                             (detReg == SEL_SPI) && pendingEn && spiTxPending;
         link.rxFull <= (detReg == SEL_SPI) && rxFullEn && rxBusy;
      end
   end

   // management clock, only once ethernet is chosen
   logic [7:0] mgmtCntReg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mgmtCntReg <= 8'h00;
         phyMgmtClockOut <= 1'b0;
      end else if (detReg != SEL_ETH) begin
         mgmtCntReg <= 8'h00;
         phyMgmtClockOut <= 1'b0;
      end else if (mgmtCntReg == 8'(hsio_pkg::MGMT_HALF_CYCLES - 1)) begin
         mgmtCntReg <= 8'h00;
         phyMgmtClockOut <= ~phyMgmtClockOut;
      end else begin
         mgmtCntReg <= mgmtCntReg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start-up buttons
   logic [3:0] startCntReg;
   logic holdReg;
   logic [31:0] holdCntReg;

   // catch the buttons once, then time the long hold
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         startCntReg <= 4'h0;
         holdReg <= 1'b0;
         holdCntReg <= 32'h0;
         restoreSerialPulse <= 1'b0;
         bootloaderMode <= 1'b0;
         factoryRestorePulse <= 1'b0;
      end else begin
         restoreSerialPulse <= 1'b0;
         factoryRestorePulse <= 1'b0;
         if (startCntReg != 4'(hsio_pkg::BUTTON_SAMPLE_CYCLES)) begin
            startCntReg <= startCntReg + 4'h1;
            if (startCntReg == 4'(hsio_pkg::BUTTON_SAMPLE_CYCLES - 1)) begin
               restoreSerialPulse <= !restoreS && connectS;
               bootloaderMode <= !restoreS && !connectS;
               holdReg <= !restoreS && !connectS;
            end
         end else if (holdReg) begin
            if (restoreS || connectS) begin
               holdReg <= 1'b0;
            end else if (holdCntReg == 32'(FACTORY_HOLD_CYCLES - 1)) begin
               holdReg <= 1'b0;
               bootloaderMode <= 1'b0;
               factoryRestorePulse <= 1'b1;
            end else begin
               holdCntReg <= holdCntReg + 32'h1;
            end
         end
      end
   end

   // connect button and host state pin requests
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         connectReq <= 1'b0;
         cmdModeReq <= 1'b0;
         disconnectReq <= 1'b0;
      end else begin
         connectReq <= connectPrev && !connectS && !bootloaderMode &&
                       startCntReg == 4'(hsio_pkg::BUTTON_SAMPLE_CYCLES);
         cmdModeReq <= hostStatePrev && !hostStateS && hostPinIsCmd;
         disconnectReq <= hostStatePrev && !hostStateS && !hostPinIsCmd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lamps
   logic [7:0] flashCntReg;
   logic linkUp;
   assign linkUp = (statusMode == hsio_pkg::ST_CONNECTING) ||
                   (statusMode == hsio_pkg::ST_CONNECTED);

   // blank timer on data activity
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flashCntReg <= 8'h00;
      end else if (dataActivity && linkUp) begin
         flashCntReg <= 8'(hsio_pkg::FLASH_CYCLES);
      end else if (flashCntReg != 8'h00) begin
         flashCntReg <= flashCntReg - 8'h01;
      end
   end

   // colour encoding, off while ethernet owns the pins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lampGreenN <= 1'b1;
         lampBlueN <= 1'b1;
         lampRedN <= 1'b1;
      end else if (detReg == SEL_ETH || (flashCntReg != 8'h00 && linkUp)) begin
         lampGreenN <= 1'b1;
         lampBlueN <= 1'b1;
         lampRedN <= 1'b1;
      end else begin
         lampGreenN <= !(statusMode == hsio_pkg::ST_DATA_IDLE ||
                         statusMode == hsio_pkg::ST_CMD_IDLE);
         lampBlueN <= !linkUp;
         lampRedN <= !(statusMode == hsio_pkg::ST_CMD_IDLE ||
                       statusMode == hsio_pkg::ST_CONNECTING);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial transmitter
   // bits in a frame with parity, start and stop included
   localparam int UART_FRAME_PAR = hsio_pkg::UART_DATA_BITS + hsio_pkg::UART_STOP_BITS + 2;
   logic [BAUD_W-1:0] baudCntReg;
   logic [10:0] frameReg;
   logic [3:0] bitsLeftReg;
   logic serialOn;
   assign serialOn = (hostIf == hsio_pkg::IF_UART) || (hostIf == hsio_pkg::IF_ETH);

   // start, 8 data, optional even parity, one stop
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         baudCntReg <= '0;
         frameReg <= 11'h7ff;
         bitsLeftReg <= 4'h0;
         txReady <= 1'b0;
         link.uartFromDev <= 1'b1;
      end else if (bitsLeftReg == 4'h0) begin
         link.uartFromDev <= 1'b1;
         txReady <= serialOn && !(flowCtrlEn && ctsS && hostIf != hsio_pkg::IF_ETH);
         if (txValid && txReady) begin
            txReady <= 1'b0;
            baudCntReg <= baudDiv;
            link.uartFromDev <= 1'b0;
            frameReg <= parityEven ? {1'b1, ^txData, txData, 1'b0} :
                                     {2'b11, txData, 1'b0};
            bitsLeftReg <= parityEven ? 4'(UART_FRAME_PAR) : 4'(UART_FRAME_PAR - 1);
         end
      end else if (baudCntReg == '0) begin
         baudCntReg <= baudDiv;
         frameReg <= {1'b1, frameReg[10:1]};
         link.uartFromDev <= frameReg[1];
         bitsLeftReg <= bitsLeftReg - 4'h1;
      end else begin
         baudCntReg <= baudCntReg - 1'b1;
      end
   end

   // handshake pins, plain GPIO without flow control, rts held high for ethernet
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link.rtsN <= 1'b1;
         gpioCtsIn <= 1'b1;
      end else begin
         gpioCtsIn <= ctsS;
         if (hostIf == hsio_pkg::IF_ETH) begin
            link.rtsN <= 1'b1;
         end else if (flowCtrlEn) begin
            link.rtsN <= rxBusy;
         end else begin
            link.rtsN <= gpioRtsOut;
         end
      end
   end
endmodule
`default_nettype wire

// *** core/hsio_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// host end: serial peripheral master and simple line drivers
module hsio_host #(
   parameter int SCLK_HALF_CYCLES = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link to the module
   hsio_link_if.host link,
   // transfer request
   input wire logic startXfer,
   input wire logic [10:0] xferWords,
   input wire logic [7:0] txByte,
   output logic byteReq,
   output logic busy,
   output logic rxValid,
   output logic [7:0] rxByte,
   // plain lines
   input wire logic uartLineOut,
   input wire logic clearToSendN,
   input wire logic hostStateIn,
   output logic uartLineIn,
   output logic pendingSeen,
   output logic rxFullSeen,
   output logic rtsSeenN
);
   logic [3:0] syncOut;
   hsio_sync3 #(.W(4), .INIT(4'h9)) uSync (
      .clk(core_clk),
      .rst_n(rst_n),
      .din({link.uartFromDev, link.dataPending, link.rxFull, link.rtsN}),
      .dout(syncOut)
   );

   // registered line states
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link.uartToDev <= 1'b1;
         link.ctsN <= 1'b1;
         link.hostStateN <= 1'b1;
         uartLineIn <= 1'b1;
         pendingSeen <= 1'b0;
         rxFullSeen <= 1'b0;
         rtsSeenN <= 1'b1;
      end else begin
         link.uartToDev <= uartLineOut;
         link.ctsN <= clearToSendN;
         link.hostStateN <= hostStateIn;
         {uartLineIn, pendingSeen, rxFullSeen, rtsSeenN} <= syncOut;
      end
   end

   logic [7:0] halfCntReg;
   logic [12:0] bytesLeftReg;
   logic [2:0] bitReg;
   logic [7:0] txShiftReg;
   logic [7:0] rxShiftReg;

   // mode 3 master, clock idles high, length clamped to 8..4096
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link.spiClk <= 1'b1;
         link.spiCsN <= 1'b1;
         link.spiMosi <= 1'b0;
         halfCntReg <= 8'h00;
         bytesLeftReg <= 13'h0000;
         bitReg <= 3'h0;
         txShiftReg <= 8'h00;
         rxShiftReg <= 8'h00;
         busy <= 1'b0;
         byteReq <= 1'b0;
         rxValid <= 1'b0;
         rxByte <= 8'h00;
      end else begin
         byteReq <= 1'b0;
         rxValid <= 1'b0;
         if (!busy) begin
            if (startXfer) begin
               busy <= 1'b1;
               link.spiCsN <= 1'b0;
               txShiftReg <= txByte;
               bitReg <= 3'h0;
               halfCntReg <= 8'h00;
               if (xferWords < 11'(hsio_pkg::SPI_MIN_BYTES / hsio_pkg::SPI_BYTE_GRAIN)) begin
                  bytesLeftReg <= 13'(hsio_pkg::SPI_MIN_BYTES);
               end else if (xferWords > 11'(hsio_pkg::SPI_MAX_BYTES / 4)) begin
                  bytesLeftReg <= 13'(hsio_pkg::SPI_MAX_BYTES);
               end else begin
                  bytesLeftReg <= {xferWords, 2'b00};
               end
            end
         end else if (halfCntReg != 8'(SCLK_HALF_CYCLES - 1)) begin
            halfCntReg <= halfCntReg + 8'h01;
         end else if (bytesLeftReg == 13'h0000) begin
            link.spiCsN <= 1'b1;
            busy <= 1'b0;
         end else begin
            halfCntReg <= 8'h00;
            if (link.spiClk) begin
               link.spiClk <= 1'b0;
               link.spiMosi <= txShiftReg[7];
            end else begin
               link.spiClk <= 1'b1;
               rxShiftReg <= {rxShiftReg[6:0], link.spiMiso};
               txShiftReg <= {txShiftReg[6:0], 1'b0};
               bitReg <= bitReg + 3'h1;
               if (bitReg == 3'h7) begin
                  rxValid <= 1'b1;
                  rxByte <= {rxShiftReg[6:0], link.spiMiso};
                  bytesLeftReg <= bytesLeftReg - 13'h0001;
                  txShiftReg <= txByte;
                  byteReq <= (bytesLeftReg != 13'h0001);
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/hsio_link_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
// watches the host link pins
module hsio_link_assertions (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link pins
   input wire logic spiClk,
   input wire logic spiCsN,
   input wire logic spiMosi,
   input wire logic dataPending,
   input wire logic rxFull,
   input wire logic uartToDev
);
   int cyc;
   logic [15:0] nBit;
   logic [3:0] nRise;
   logic clkQ, uSeen, rise;
   assign rise = spiClk && !clkQ;
   // cycles since reset, serial clock edges and uart activity
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc <= 0;
         clkQ <= 1'b1;
         nRise <= 4'h0;
         nBit <= 16'h0000;
         uSeen <= 1'b0;
      end else begin
         cyc <= (cyc < 1000) ? cyc + 1 : cyc;
         clkQ <= spiClk;
         nRise <= (rise && nRise < 8) ? nRise + 4'h1 : nRise;
         nBit <= spiCsN ? 16'h0000 : nBit + {15'h0000, rise};
         uSeen <= uSeen || !uartToDev;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   pend_quiet_a: assert property (cyc < 64 |-> !dataPending)
      else $error("pending moved early");
   pend_hold_a: assert property ($rose(dataPending) && nRise == 0 && !uSeen |-> dataPending [*8])
      else $error("pending high too short");
   pend_low_a: assert property ($fell(dataPending) && nRise == 0 && !uSeen |-> !dataPending [*8])
      else $error("pending low too short");
   pend_stop_a: assert property (uSeen && $past(uSeen, 12) && nRise < 8 |-> !dataPending)
      else $error("pending still toggling");
   rxfull_gate_a: assert property (nRise < 8 |-> !rxFull)
      else $error("rx full before slave port");
   clk_idle_a: assert property (spiCsN |-> spiClk)
      else $error("serial clock not idle high");
   mosi_stable_a: assert property (rise |-> $stable(spiMosi))
      else $error("mosi moved at rising edge");
   xfer_len_a: assert property ($rose(spiCsN) |-> nBit[4:0] == 0 && nBit >= 64)
      else $error("bad transaction length");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// bench for both ends of the host link
module tb_top;
   logic core_clk, rst_n, rmiiRefClk, ethOn, restoreBtnN, connectBtnN, dataActivity;
   logic hostPinIsCmd, parityEven, flowCtrlEn, pendingEn, rxFullEn, rxBusy, spiTxPending;
   logic gpioRtsOut, txValid, txReady, rxByteValid, lampGreenN, lampBlueN, lampRedN;
   logic restoreSerialPulse, bootloaderMode, factoryRestorePulse, connectReq, cmdModeReq;
   logic disconnectReq, gpioCtsIn, phyMgmtClockOut, startXfer, byteReq, busy, rxValid;
   logic uartLineOut, clearToSendN, hostStateIn, uartLineIn, pendingSeen, rxFullSeen, rtsSeenN;
   logic [15:0] baudDiv;
   logic [10:0] xferWords, fr;
   logic [7:0] txData, rxByte, txByte, hRxByte, got;
   logic [4:0] ev;
   hsio_pkg::hsio_status_e statusMode;
   hsio_pkg::hsio_if_e hostIf;
   int errors, tests_run, n;
   logic [2:0] lamp [4] = '{3'h3, 3'h2, 3'h4, 3'h5};
   hsio_link_if link ();
   hsio_device #(.FACTORY_HOLD_CYCLES(50)) hsio_device_i (.*);
   hsio_host hsio_host_i (.*, .rxByte(hRxByte));
   hsio_link_assertions hsio_link_assertions_i (.core_clk(core_clk), .rst_n(rst_n),
      .spiClk(link.spiClk), .spiCsN(link.spiCsN), .spiMosi(link.spiMosi),
      .dataPending(link.dataPending), .rxFull(link.rxFull), .uartToDev(link.uartToDev));
   // core clock
   initial begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end
   // reference clock, running only in the ethernet
   always #3 rmiiRefClk = ethOn ? ~rmiiRefClk : 1'b0;
   // sticky record of restore, connect, command, factory and disconnect pulses
   always @(posedge core_clk)
      ev <= ev | {restoreSerialPulse, connectReq, cmdModeReq, factoryRestorePulse, disconnectReq};
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rst();
      rst_n = 0;
      ev = '0;
      tick(4);
      rst_n = 1;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // cut a hung run short
   initial begin
      #2000000;
      errors++;
      print_verdict();
   end
   // main sequence
   initial begin
      {rst_n, ethOn, dataActivity, hostPinIsCmd, flowCtrlEn, txValid, startXfer} = '0;
      {restoreBtnN, connectBtnN, parityEven, pendingEn, rxFullEn, rxBusy, spiTxPending} = '1;
      {gpioRtsOut, clearToSendN, uartLineOut, hostStateIn} = 4'h3;
      {baudDiv, xferWords, txData, txByte} = {16'h0003, 11'h002, 8'h07, 8'h5a};
      statusMode = hsio_pkg::ST_DATA_IDLE;
      // serial start-up with the restore button held
      restoreBtnN = 0;
      rst();
      tick(80);
      {restoreBtnN, uartLineOut} = 2'b10;
      tick(3);
      {uartLineOut, hostPinIsCmd, hostStateIn, connectBtnN} = 4'hc;
      tick(10);
      chk(hostIf, hsio_pkg::IF_UART);
      chk(ev, 5'h1c);
      chk({gpioCtsIn, rtsSeenN}, 2'b00);
      {txValid, hostStateIn, connectBtnN} = 3'h7;
      repeat (20) if (!txReady) tick(1);
      tick(1);
      txValid = 0;
      tick(2);
      for (int i = 0; i < 11; i++) begin
         fr[i] = link.uartFromDev;
         tick(4);
      end
      chk(fr, 11'h60e);
      for (int i = 0; i < 4; i++) begin
         statusMode = hsio_pkg::hsio_status_e'(i);
         tick(3);
         chk({lampGreenN, lampBlueN, lampRedN}, lamp[i]);
      end
      dataActivity = 1;
      tick(1);
      dataActivity = 0;
      tick(2);
      chk({lampGreenN, lampBlueN, lampRedN}, 3'h7);
      $display("test 1 done");
      // slave port picked by the master's clocks, then a counted transfer
      rst();
      tick(100);
      for (int k = 0; k < 2; k++) begin
         startXfer = 1;
         tick(1);
         startXfer = 0;
         n = 0;
         repeat (200) begin
            tick(1);
            n += rxByteValid;
            if (rxValid) got = hRxByte;
         end
      end
      chk(n, 8);
      chk(hostIf, hsio_pkg::IF_SPI);
      chk({got, pendingSeen, rxFullSeen}, {8'h5a, 2'b11});
      chk(rxByte, 8'h5a);
      $display("test 2 done");
      // reference clock present at start-up
      ethOn = 1;
      rst();
      tick(100);
      chk(hostIf, hsio_pkg::IF_ETH);
      chk({lampGreenN, lampBlueN, lampRedN, rtsSeenN}, 4'hf);
      got[0] = phyMgmtClockOut;
      tick(4);
      chk(phyMgmtClockOut, !got[0]);
      ethOn = 0;
      $display("test 3 done");
      // both buttons held through start-up and beyond
      {restoreBtnN, connectBtnN, hostPinIsCmd, hostStateIn} = 4'h0;
      rst();
      tick(15);
      chk(bootloaderMode, 1);
      tick(80);
      chk({bootloaderMode, ev}, 6'h03);
      $display("test 4 done");
      print_verdict();
   end
endmodule
`default_nettype wire
